// [inc/led_driver_pkg.sv]
package led_driver_pkg;

    localparam int NUM_CHANNELS = 18;

    // Register offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_GLOBAL_CURRENT = 8'h01;
    localparam logic [7:0] ADDR_SCALE_FIRST = 8'h02;
    localparam logic [7:0] ADDR_SCALE_LAST = 8'h13;
    localparam logic [7:0] ADDR_OPEN_DETECT = 8'h14;
    localparam logic [7:0] ADDR_SPREAD = 8'h19;
    localparam logic [7:0] ADDR_DC_FORCE_FIRST = 8'h1a;
    localparam logic [7:0] ADDR_DC_FORCE_LAST = 8'h1c;
    localparam logic [7:0] ADDR_PWM_FIRST = 8'h1f;
    localparam logic [7:0] ADDR_PWM_LAST = 8'h30;
    localparam logic [7:0] ADDR_BLINK_FREQ = 8'h34;
    localparam logic [7:0] ADDR_BLINK_DUTY = 8'h35;
    localparam logic [7:0] ADDR_SCALE_UPDATE = 8'h36;
    localparam logic [7:0] ADDR_UPDATE = 8'h37;
    localparam logic [7:0] ADDR_RESET = 8'h3f;
    localparam logic [7:0] ADDR_OPEN_STATUS_FIRST = 8'h95;
    localparam logic [7:0] ADDR_OPEN_STATUS_LAST = 8'h97;

    // Command values
    localparam logic [7:0] UPDATE_KEY = 8'h00;
    localparam logic [7:0] RESET_KEY = 8'hae;

    // Field positions
    localparam int CFG_SOFT_SHUTDOWN_N_BIT = 0;
    localparam int CFG_PWM_FAST_BIT = 1;
    localparam int CFG_LOW_CURRENT_RANGE_BIT = 5;
    localparam int OD_ENABLE_BIT = 0;
    localparam int OD_REPORT_BIT = 1;
    localparam int SPREAD_CYCLE_LSB = 0;
    localparam int SPREAD_RANGE_LSB = 2;
    localparam int SPREAD_ENABLE_BIT = 4;
    localparam int DC_LOW_LSB = 0;
    localparam int DC_HIGH_LSB = 4;
    localparam int DC_PER_REG = 6;
    localparam int DC_PER_GROUP = 3;
    localparam int STATUS_PER_REG = 8;

    // Values after reset
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic RESET_IRQ_N = 1'b1;

    // PWM timing: one period is 256 steps of the shared counter
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWM_STEPS = 256;
    localparam int PWM_SLOW_PERIOD_NS = 5000000;
    localparam int PWM_FAST_PERIOD_NS = 40000;
    localparam int PWM_SLOW_STEP_CYCLES = PWM_SLOW_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS);
    localparam int PWM_FAST_STEP_CYCLES = PWM_FAST_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS);
    localparam int PRESCALE_WIDTH = 11;

endpackage : led_driver_pkg

// [src/led_pwm_shutdown_open_detect.sv]
module led_pwm_shutdown_open_detect
    import led_driver_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic hw_shutdown_n,
    input wire logic [NUM_CHANNELS-1:0] open_sense,
    output logic [NUM_CHANNELS-1:0] led_channel,
    output logic [NUM_CHANNELS-1:0][7:0] channel_scale,
    output logic [7:0] global_current,
    output logic low_current_range,
    output logic spread_enable,
    output logic [1:0] spread_range,
    output logic [1:0] spread_cycle,
    output logic fault_irq_n,
    output logic iface_reset
);

    typedef struct packed {
        logic soft_shutdown_n;
        logic pwm_fast;
        logic low_current_range;
        logic [7:0] global_current;
        logic [NUM_CHANNELS-1:0][7:0] scale_pending;
        logic [NUM_CHANNELS-1:0][7:0] scale_active;
        logic [NUM_CHANNELS-1:0][7:0] pwm_pending;
        logic [NUM_CHANNELS-1:0][7:0] pwm_active;
        logic [7:0] blink_freq_pending;
        logic [7:0] blink_freq_active;
        logic [7:0] blink_duty_pending;
        logic [7:0] blink_duty_active;
        logic [NUM_CHANNELS-1:0] dc_force;
        logic open_detect_enable;
        logic open_fault_report_en;
        logic spread_enable;
        logic [1:0] spread_range;
        logic [1:0] spread_cycle;
        logic [NUM_CHANNELS-1:0] open_status;
    } regs_t;

    typedef struct packed {
        regs_t regs;
        logic [PRESCALE_WIDTH-1:0] prescale;
        logic [7:0] pwm_count;
        logic hw_shutdown_prev;
        logic open_detect_prev;
        logic fault_irq_n;
        logic iface_reset;
        logic [7:0] rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic [NUM_CHANNELS-1:0] channel_drive;
    logic channels_enabled;
    logic [4:0] scale_idx;
    logic [4:0] pwm_idx;
    logic [1:0] dc_idx;
    logic [1:0] status_idx;
    logic [PRESCALE_WIDTH-1:0] step_limit;
    logic [7:0] rd_value;

    assign scale_idx = 5'(addr - ADDR_SCALE_FIRST);
    assign pwm_idx = 5'(addr - ADDR_PWM_FIRST);
    assign dc_idx = 2'(addr - ADDR_DC_FORCE_FIRST);
    assign status_idx = 2'(addr - ADDR_OPEN_STATUS_FIRST);

    // Both shutdowns only gate the sinks; no register is touched here
    assign channels_enabled = s_reg.regs.soft_shutdown_n && hw_shutdown_n;

    always_comb begin
        if (s_reg.regs.pwm_fast) begin
            step_limit = PRESCALE_WIDTH'(PWM_FAST_STEP_CYCLES - 1);
        end else begin
            step_limit = PRESCALE_WIDTH'(PWM_SLOW_STEP_CYCLES - 1);
        end
    end

    // Read mux; unmapped and write-only command addresses read as zero
    always_comb begin
        rd_value = RESET_BYTE;
        if (addr == ADDR_CONFIG) begin
            rd_value[CFG_SOFT_SHUTDOWN_N_BIT] = s_reg.regs.soft_shutdown_n;
            rd_value[CFG_PWM_FAST_BIT] = s_reg.regs.pwm_fast;
            rd_value[CFG_LOW_CURRENT_RANGE_BIT] = s_reg.regs.low_current_range;
        end else if (addr == ADDR_GLOBAL_CURRENT) begin
            rd_value = s_reg.regs.global_current;
        end else if (addr >= ADDR_SCALE_FIRST && addr <= ADDR_SCALE_LAST) begin
            rd_value = s_reg.regs.scale_pending[scale_idx];
        end else if (addr == ADDR_OPEN_DETECT) begin
            rd_value[OD_ENABLE_BIT] = s_reg.regs.open_detect_enable;
            rd_value[OD_REPORT_BIT] = s_reg.regs.open_fault_report_en;
        end else if (addr == ADDR_SPREAD) begin
            rd_value[SPREAD_CYCLE_LSB +: 2] = s_reg.regs.spread_cycle;
            rd_value[SPREAD_RANGE_LSB +: 2] = s_reg.regs.spread_range;
            rd_value[SPREAD_ENABLE_BIT] = s_reg.regs.spread_enable;
        end else if (addr >= ADDR_DC_FORCE_FIRST && addr <= ADDR_DC_FORCE_LAST) begin
            for (int b = 0; b < DC_PER_GROUP; b++) begin
                rd_value[DC_LOW_LSB + b] = s_reg.regs.dc_force[dc_idx * DC_PER_REG + b];
                rd_value[DC_HIGH_LSB + b] = s_reg.regs.dc_force[dc_idx * DC_PER_REG + DC_PER_GROUP + b];
            end
        end else if (addr >= ADDR_PWM_FIRST && addr <= ADDR_PWM_LAST) begin
            rd_value = s_reg.regs.pwm_pending[pwm_idx];
        end else if (addr == ADDR_BLINK_FREQ) begin
            rd_value = s_reg.regs.blink_freq_pending;
        end else if (addr == ADDR_BLINK_DUTY) begin
            rd_value = s_reg.regs.blink_duty_pending;
        end else if (addr >= ADDR_OPEN_STATUS_FIRST && addr <= ADDR_OPEN_STATUS_LAST) begin
            for (int b = 0; b < STATUS_PER_REG; b++) begin
                if (status_idx * STATUS_PER_REG + b < NUM_CHANNELS) begin
                    rd_value[b] = s_reg.regs.open_status[status_idx * STATUS_PER_REG + b];
                end
            end
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.iface_reset = 1'b0;
        s_next.rdata = RESET_BYTE;

        // Shared step prescaler and period counter for every channel
        if (s_reg.prescale >= step_limit) begin
            s_next.prescale = '0;
            s_next.pwm_count = s_reg.pwm_count + 8'h01;
        end else begin
            s_next.prescale = s_reg.prescale + PRESCALE_WIDTH'(1);
        end

        // Pin rising edge only restarts the serial engine outside
        s_next.hw_shutdown_prev = hw_shutdown_n;
        if (hw_shutdown_n && !s_reg.hw_shutdown_prev) begin
            s_next.iface_reset = 1'b1;
        end

        // Register port is served regardless of either shutdown
        if (rd_en) begin
            s_next.rdata = rd_value;
        end

        // Open status capture
        s_next.open_detect_prev = s_reg.regs.open_detect_enable;
        if (s_reg.regs.open_detect_enable && !s_reg.open_detect_prev) begin
            s_next.regs.open_status = '0;
        end else if (s_reg.regs.open_detect_enable) begin
            // An off sink gives no valid reading, so its last result is kept
            for (int c = 0; c < NUM_CHANNELS; c++) begin
                if (channel_drive[c]) begin
                    s_next.regs.open_status[c] = open_sense[c];
                end
            end
        end

        s_next.fault_irq_n = !(s_reg.regs.open_fault_report_en && (|s_reg.regs.open_status));

        if (wr_en) begin
            if (addr == ADDR_CONFIG) begin
                s_next.regs.soft_shutdown_n = wdata[CFG_SOFT_SHUTDOWN_N_BIT];
                s_next.regs.pwm_fast = wdata[CFG_PWM_FAST_BIT];
                s_next.regs.low_current_range = wdata[CFG_LOW_CURRENT_RANGE_BIT];
            end else if (addr == ADDR_GLOBAL_CURRENT) begin
                s_next.regs.global_current = wdata;
            end else if (addr >= ADDR_SCALE_FIRST && addr <= ADDR_SCALE_LAST) begin
                s_next.regs.scale_pending[scale_idx] = wdata;
            end else if (addr == ADDR_OPEN_DETECT) begin
                s_next.regs.open_detect_enable = wdata[OD_ENABLE_BIT];
                s_next.regs.open_fault_report_en = wdata[OD_REPORT_BIT];
            end else if (addr == ADDR_SPREAD) begin
                s_next.regs.spread_cycle = wdata[SPREAD_CYCLE_LSB +: 2];
                s_next.regs.spread_range = wdata[SPREAD_RANGE_LSB +: 2];
                s_next.regs.spread_enable = wdata[SPREAD_ENABLE_BIT];
            end else if (addr >= ADDR_DC_FORCE_FIRST && addr <= ADDR_DC_FORCE_LAST) begin
                for (int b = 0; b < DC_PER_GROUP; b++) begin
                    s_next.regs.dc_force[dc_idx * DC_PER_REG + b] = wdata[DC_LOW_LSB + b];
                    s_next.regs.dc_force[dc_idx * DC_PER_REG + DC_PER_GROUP + b] = wdata[DC_HIGH_LSB + b];
                end
            end else if (addr >= ADDR_PWM_FIRST && addr <= ADDR_PWM_LAST) begin
                s_next.regs.pwm_pending[pwm_idx] = wdata;
            end else if (addr == ADDR_BLINK_FREQ) begin
                s_next.regs.blink_freq_pending = wdata;
            end else if (addr == ADDR_BLINK_DUTY) begin
                s_next.regs.blink_duty_pending = wdata;
            end else if (addr == ADDR_SCALE_UPDATE && wdata == UPDATE_KEY) begin
                s_next.regs.scale_active = s_reg.regs.scale_pending;
            end else if (addr == ADDR_UPDATE && wdata == UPDATE_KEY) begin
                s_next.regs.pwm_active = s_reg.regs.pwm_pending;
                s_next.regs.blink_freq_active = s_reg.regs.blink_freq_pending;
                s_next.regs.blink_duty_active = s_reg.regs.blink_duty_pending;
            end else if (addr == ADDR_RESET && wdata == RESET_KEY) begin
                // Software reset also drops soft_shutdown_n, blanking the outputs
                s_next.regs = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.fault_irq_n <= RESET_IRQ_N;
            s_reg.hw_shutdown_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // One comparator per channel against the shared count
    for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_channel
        pwm_channel u_channel (
            .clk(clk),
            .rst_n(rst_n),
            .count(s_reg.pwm_count),
            .duty(s_reg.regs.pwm_active[c]),
            .dc_force(s_reg.regs.dc_force[c]),
            .enable(channels_enabled),
            .drive(channel_drive[c])
        );
    end

    assign led_channel = channel_drive;
    assign channel_scale = s_reg.regs.scale_active;
    assign global_current = s_reg.regs.global_current;
    assign low_current_range = s_reg.regs.low_current_range;
    assign spread_enable = s_reg.regs.spread_enable;
    assign spread_range = s_reg.regs.spread_range;
    assign spread_cycle = s_reg.regs.spread_cycle;
    assign fault_irq_n = s_reg.fault_irq_n;
    assign iface_reset = s_reg.iface_reset;
    assign rdata = s_reg.rdata;

endmodule : led_pwm_shutdown_open_detect

// [src/pwm_channel.sv]
module pwm_channel
    import led_driver_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] count,
    input wire logic [7:0] duty,
    input wire logic dc_force,
    input wire logic enable,
    output logic drive
);

    typedef struct packed {
        logic drive;
    } channel_state_t;

    channel_state_t s_reg;
    channel_state_t s_next;

    always_comb begin
        s_next = s_reg;
        // Duty 0 never turns on; dc_force bypasses the compare entirely
        s_next.drive = enable && (dc_force || (count < duty));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign drive = s_reg.drive;

endmodule : pwm_channel

// [verification/host_model.sv]
module host_model
    import led_driver_pkg::*;
(
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    // Keys go through wr: pending values are committed by the host
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        // Let the write edge settle so a caller's check sees the new state
        #1;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd
endmodule : host_model

// [verification/led_pwm_checker.sv]
module led_pwm_checker
    import led_driver_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic hw_shutdown_n,
    input wire logic [NUM_CHANNELS-1:0] led_channel,
    input wire logic [NUM_CHANNELS-1:0][7:0] channel_scale,
    input wire logic [7:0] global_current,
    input wire logic low_current_range,
    input wire logic spread_enable,
    input wire logic [1:0] spread_range,
    input wire logic [1:0] spread_cycle,
    input wire logic fault_irq_n,
    input wire logic iface_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence pin_rise_s;
        !hw_shutdown_n ##1 hw_shutdown_n;
    endsequence
    sequence soft_off_s;
        wr_en && addr == ADDR_CONFIG && !wdata[CFG_SOFT_SHUTDOWN_N_BIT] ##1 !(wr_en && addr == ADDR_CONFIG);
    endsequence
    pin_off_a: assert property (!hw_shutdown_n [*3] |-> led_channel == '0) else $error("sink on in pin shutdown");
    soft_off_a: assert property (soft_off_s |=> led_channel == '0) else $error("sink on in soft shutdown");
    iface_pulse_a: assert property (pin_rise_s |=> iface_reset ##1 !iface_reset) else $error("no reset pulse");
    iface_cause_a: assert property (iface_reset |-> $past(hw_shutdown_n) && !$past(hw_shutdown_n, 2))
        else $error("stray reset pulse");
    regs_keep_a: assert property (!wr_en |=> $stable(global_current) && $stable(channel_scale) && $stable(spread_range))
        else $error("register changed without write");
    scale_hold_a: assert property (wr_en && addr inside {[ADDR_SCALE_FIRST:ADDR_SCALE_LAST]} |=> $stable(channel_scale))
        else $error("scale applied before update");
    range_bit_a: assert property (wr_en && addr == ADDR_CONFIG |=> low_current_range == $past(wdata[5]))
        else $error("range bit wrong");
    spread_field_a: assert property (wr_en && addr == ADDR_SPREAD
        |=> {spread_enable, spread_range, spread_cycle} == $past(wdata[4:0])) else $error("spread fields wrong");
    read_gc_a: assert property (rd_en && addr == ADDR_GLOBAL_CURRENT |=> rdata == $past(global_current))
        else $error("read data wrong");
    irq_mask_a: assert property (wr_en && addr == ADDR_OPEN_DETECT && !wdata[OD_REPORT_BIT] |-> ##[2:3] fault_irq_n)
        else $error("fault output not released");
endmodule : led_pwm_checker

bind led_pwm_shutdown_open_detect led_pwm_checker chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .hw_shutdown_n(hw_shutdown_n), .led_channel(led_channel),
    .channel_scale(channel_scale), .global_current(global_current), .low_current_range(low_current_range),
    .spread_enable(spread_enable), .spread_range(spread_range), .spread_cycle(spread_cycle),
    .fault_irq_n(fault_irq_n), .iface_reset(iface_reset));

// [verification/led_pwm_shutdown_open_detect_tb_top.sv]
module led_pwm_shutdown_open_detect_tb_top
    import led_driver_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, wr_en, rd_en, hw_shutdown_n, low_current_range, spread_enable, fault_irq_n, iface_reset;
    logic [7:0] addr, wdata, rdata, global_current, got, d;
    logic [1:0] spread_range, spread_cycle;
    logic [NUM_CHANNELS-1:0] open_sense, led_channel;
    logic [NUM_CHANNELS-1:0][7:0] channel_scale;
    int err_count, cmp_count, seed, n, hi, per;
    int regs[256];
    int scale_act[NUM_CHANNELS];
    led_pwm_shutdown_open_detect dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .hw_shutdown_n(hw_shutdown_n), .open_sense(open_sense),
        .led_channel(led_channel), .channel_scale(channel_scale), .global_current(global_current),
        .low_current_range(low_current_range), .spread_enable(spread_enable), .spread_range(spread_range),
        .spread_cycle(spread_cycle), .fault_irq_n(fault_irq_n), .iface_reset(iface_reset));
    host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t %s: got %0h expected %0h", $time, m, g, e);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a);
        host.rd(a, got);
        chk(got, regs[a], "read back");
    endtask : rd_chk
    task automatic cmp_scale();
        for (int c = 0; c < NUM_CHANNELS; c++) chk(channel_scale[c], scale_act[c], "scale");
    endtask : cmp_scale
    task automatic wait_lvl(input int c, input logic v);
        n = 0;
        while (led_channel[c] !== v && n < 9000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_lvl
    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        #600000;
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        seed = 40;
        rst_n = 1'b0;
        hw_shutdown_n = 1'b1;
        open_sense = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[a]) rd_chk(a[7:0]);
        chk(fault_irq_n, 1'b1, "irq after reset");
        $display("reset values done");
        for (int a = 1; a <= 8'h35; a++) begin
            if ((a > 8'h13 && a < 8'h1f) || (a > 8'h30 && a < 8'h34)) continue;
            // Global current kept inside the range where open detection is valid
            d = (a == 1) ? 8'h0f + 8'($random(seed) & 31) : 8'($random(seed));
            host.wr(a[7:0], d);
            regs[a] = d;
        end
        host.wr(8'h50, 8'h5a);
        for (int a = 1; a <= 8'h50; a++) rd_chk(a[7:0]);
        cmp_scale();
        host.wr(ADDR_SCALE_UPDATE, 8'h01);
        cmp_scale();
        host.wr(ADDR_SCALE_UPDATE, UPDATE_KEY);
        foreach (scale_act[c]) scale_act[c] = regs[ADDR_SCALE_FIRST + c];
        cmp_scale();
        $display("register file done");
        for (int r = 0; r < 4; r++) begin
            host.wr(ADDR_SPREAD, 8'(16 + r * 4 + (3 - r)));
            chk({spread_enable, spread_range, spread_cycle}, 16 + r * 4 + (3 - r), "spread");
        end
        host.wr(ADDR_CONFIG, 8'h20);
        chk(low_current_range, 1'b1, "range bit");
        host.wr(ADDR_CONFIG, 8'h00);
        chk(low_current_range, 1'b0, "range bit");
        host.wr(ADDR_DC_FORCE_FIRST, 8'h01);
        repeat (5) @(posedge clk);
        chk(led_channel, 0, "soft shutdown");
        host.wr(ADDR_CONFIG, 8'h03);
        repeat (2) @(posedge clk);
        chk(led_channel[0], 1'b1, "dc force");
        hw_shutdown_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(led_channel, 0, "pin shutdown");
        host.wr(ADDR_GLOBAL_CURRENT, 8'h2a);
        regs[1] = 8'h2a;
        chk(global_current, 8'h2a, "global current");
        rd_chk(ADDR_GLOBAL_CURRENT);
        @(posedge clk);
        hw_shutdown_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(iface_reset, 1'b1, "iface pulse");
        @(posedge clk);
        chk(iface_reset, 1'b0, "iface pulse end");
        chk(led_channel[0], 1'b1, "resume");
        rd_chk(ADDR_GLOBAL_CURRENT);
        $display("shutdown done");
        host.wr(ADDR_PWM_FIRST + 8'h01, 8'h80);
        host.wr(ADDR_PWM_FIRST + 8'h02, 8'h40);
        wait_lvl(1, 1'b1);
        chk(n, 9000, "pwm pending");
        host.wr(ADDR_UPDATE, UPDATE_KEY);
        // A mid-period update may switch the sink on at once; skip that partial pulse
        repeat (2) @(posedge clk);
        wait_lvl(1, 1'b0);
        wait_lvl(1, 1'b1);
        chk(led_channel[2], 1'b1, "aligned start");
        hi = 0;
        while (led_channel[1] === 1'b1 && hi < 9000) begin
            @(posedge clk);
            hi++;
        end
        per = hi;
        while (led_channel[1] === 1'b0 && per < 9000) begin
            @(posedge clk);
            per++;
        end
        chk(hi, 128 * PWM_FAST_STEP_CYCLES, "high time");
        chk(per, PWM_STEPS * PWM_FAST_STEP_CYCLES, "period");
        $display("pwm done");
        open_sense <= 18'h00001;
        host.wr(ADDR_OPEN_DETECT, 8'h03);
        repeat (4) @(posedge clk);
        regs[ADDR_OPEN_STATUS_FIRST] = 1;
        rd_chk(ADDR_OPEN_STATUS_FIRST);
        chk(fault_irq_n, 1'b0, "fault report");
        host.wr(ADDR_OPEN_DETECT, 8'h01);
        repeat (3) @(posedge clk);
        chk(fault_irq_n, 1'b1, "fault masked");
        host.wr(ADDR_OPEN_DETECT, 8'h00);
        open_sense <= '0;
        repeat (4) @(posedge clk);
        rd_chk(ADDR_OPEN_STATUS_FIRST);
        host.wr(ADDR_OPEN_DETECT, 8'h01);
        repeat (4) @(posedge clk);
        regs[ADDR_OPEN_STATUS_FIRST] = 0;
        rd_chk(ADDR_OPEN_STATUS_FIRST);
        $display("open detect done");
        host.wr(ADDR_RESET, RESET_KEY);
        foreach (regs[a]) regs[a] = 0;
        rd_chk(ADDR_GLOBAL_CURRENT);
        rd_chk(ADDR_PWM_FIRST);
        chk(led_channel, 0, "off after reset key");
        $display("reset key done");
        stop_test();
    end
endmodule : led_pwm_shutdown_open_detect_tb_top
